// ### hdl/clamp_cfg_pkg.sv
// Constants, field layouts and state types of the clamp and filter configuration bank
package clamp_cfg_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_IDENT = 6'h11;
  localparam logic [5:0] IDX_TIMING = 6'h12;
  localparam logic [5:0] IDX_ICTRL = 6'h13;
  localparam logic [5:0] IDX_CLAMP = 6'h14;
  localparam logic [5:0] IDX_DC_HI = 6'h15;
  localparam logic [5:0] IDX_DC_LO = 6'h16;
  localparam logic [5:0] IDX_FILT = 6'h17;

  // Reset values
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [7:0] ICTRL_RST = 8'h45;
  localparam logic [7:0] CLAMP_RST = 8'h30;
  localparam logic [7:0] DC_HI_RST = 8'h00;
  localparam logic [7:0] DC_LO_RST = 8'h00;
  localparam logic [7:0] FILT_RST = 8'h00;
  // Revision byte; the value is arbitrary
  localparam logic [7:0] REVISION_DEFAULT = 8'h5a;

  // Field positions
  localparam int TIMING_DISABLE_BIT = 0;
  localparam int FORCE_BIT = 1;
  localparam int FINE_LSB = 0;
  localparam int FAST_LSB = 2;
  localparam int CURRENT_EN_BIT = 4;
  localparam int VOLTAGE_EN_BIT = 5;
  localparam logic [7:0] CLAMP_WMASK = 8'h3f;
  localparam int OFS_HI_LSB = 0;
  localparam int FREEZE_BIT = 4;
  localparam int TCONST_LSB = 5;
  localparam int MODE_BIT = 7;
  localparam int LUMA_LSB = 0;
  localparam int CHROMA_LSB = 5;

  // Codes
  localparam logic [4:0] LUMA_UNUSED = 5'h1e;
  localparam logic [2:0] CHROMA_AUTO_15 = 3'h0;
  localparam logic [2:0] CHROMA_AUTO_217 = 3'h1;
  localparam logic [2:0] CHROMA_SH1 = 3'h2;
  localparam logic [2:0] CHROMA_SH2 = 3'h3;
  localparam logic [1:0] TCONST_SLOW = 2'h0;
  localparam logic [1:0] TCONST_MEDIUM = 2'h1;
  localparam logic [1:0] TCONST_FAST = 2'h2;
  localparam logic [1:0] TCONST_QUALITY = 2'h3;

  // Timing
  localparam longint unsigned CLK_HZ = 10_000_000;
  localparam longint unsigned TC_SLOW_MS = 1000;
  localparam longint unsigned TC_MEDIUM_MS = 500;
  localparam longint unsigned TC_FAST_MS = 100;
  localparam longint unsigned TC_SLOW_CYC = TC_SLOW_MS * CLK_HZ / 1000;
  localparam longint unsigned TC_MEDIUM_CYC = TC_MEDIUM_MS * CLK_HZ / 1000;
  localparam longint unsigned TC_FAST_CYC = TC_FAST_MS * CLK_HZ / 1000;
  localparam logic [7:0] CLAMP_BASE_LEN = 8'h10;
  localparam int TC_CNT_W = 24;

  typedef struct packed {
    logic active;
    logic [7:0] cnt;
    logic [7:0] len;
  } pulse_state_t;

  typedef struct packed {
    logic [7:0] timing;
    logic [7:0] ictrl;
    logic [7:0] clamp;
    logic [7:0] dc_hi;
    logic [7:0] dc_lo;
    logic [7:0] filt;
    logic wr_pend;
    logic [5:0] wr_idx;
    logic [7:0] rdata;
    logic [11:0] core_data;
    logic [TC_CNT_W-1:0] tc_cnt;
    logic tick;
  } cfg_state_t;

endpackage

// ### hdl/clamp_pulse_timer.sv
// Clamp current pulse timer: holds its output for 16 << code cycles after a start
`timescale 1ns/1ps
`default_nettype none
module clamp_pulse_timer
  import clamp_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [1:0] code,
  output logic active
);
  pulse_state_t s_q;
  pulse_state_t s_d;
  logic [7:0] run_len_q;

  always_comb begin
    s_d = s_q;
    if (start) begin
      // Length is latched so a rewrite mid-pulse only affects the next pulse
      s_d.active = 1'b1;
      s_d.len = 8'(CLAMP_BASE_LEN << code);
      s_d.cnt = 8'(CLAMP_BASE_LEN << code) - 8'h01;
    end else if (s_q.active) begin
      if (s_q.cnt == 8'h00) begin
        s_d.active = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign active = s_q.active;

  // Helper: length of the current high run, counted in enabled cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_len_q <= 8'h00;
    end else if (ce) begin
      run_len_q <= s_d.active ? ((start || !s_q.active) ? 8'h01 : run_len_q + 8'h01) : 8'h00;
    end
  end

  property p_pulse_len;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s_q.active && !s_d.active) |-> (run_len_q == s_q.len);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("clamp pulse length wrong");
endmodule
`default_nettype wire

// ### hdl/video_clamp_filter_config_regs.sv
// Clamp, timing-output and shaping-filter configuration bank on AHB-Lite
//
// Behaviour
// - Revision byte is read-only; writes leave it unchanged.
// - Force bit 0: sync/field drivers follow output-enable pin and disable bit; 1: always on.
// - Fine clamp length bits 1:0 give 16, 32, 64 or 128 slow-current cycles.
// - Fast clamp length bits 3:2 give 16, 32, 64 or 128 fast-current cycles.
// - Bit 4 off switches current sources off, on enables them.
// - Bit 5 enables voltage clamp; bits 7:6 reserved, held zero.
// - 12-bit offset from two registers is added to raw data in manual mode only.
// - Freeze bit holds the digital clamp loop; clear lets it run.
// - Time constant codes: 1 s, 0.5 s, 0.1 s, or quality dependent.
// - Mode bit 0 automatic clamp, 1 manual offset correction.
// - Chroma field bits 7:5: auto 1.5 MHz, auto 2.17 MHz, fixed SH1 to SH6.
// - Luma field bits 4:0 selects notch, SVHS, PAL, NTSC filters; 11110 unused.
// - Automatic chroma choice follows the current scaling factor.
`timescale 1ns/1ps
`default_nettype none
module video_clamp_filter_config_regs
  import clamp_cfg_pkg::*;
#(
  parameter logic [7:0] REVISION = REVISION_DEFAULT,
  parameter int unsigned TC_SLOW_CYCLES = 32'(TC_SLOW_CYC),
  parameter int unsigned TC_MEDIUM_CYCLES = 32'(TC_MEDIUM_CYC),
  parameter int unsigned TC_FAST_CYCLES = 32'(TC_FAST_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic output_enable_n,
  output logic timing_drive_en,
  input wire logic clamp_start,
  output logic fine_current_on,
  output logic fast_current_on,
  output logic voltage_clamp_on,
  input wire logic video_quality_indication,
  output logic digital_clamp_run,
  output logic digital_clamp_tick,
  output logic manual_offset_mode,
  output logic [11:0] digital_clamp_offset,
  input wire logic [11:0] adc_raw,
  output logic [11:0] core_data,
  output logic [4:0] luma_filter_select,
  output logic luma_filter_valid,
  output logic [2:0] chroma_filter_select,
  input wire logic [1:0] scale_range,
  output logic [2:0] chroma_filter_active
);

  // Counter holds period minus one; a period longer than the counter range stops elaboration with an error
  if (TC_SLOW_CYCLES == 0 || TC_MEDIUM_CYCLES == 0 || TC_FAST_CYCLES == 0) begin : g_tc_zero
    $error("time constant periods must be nonzero");
  end
  if (TC_SLOW_CYCLES > 2 ** TC_CNT_W || TC_MEDIUM_CYCLES > 2 ** TC_CNT_W
      || TC_FAST_CYCLES > 2 ** TC_CNT_W) begin : g_tc_wide
    $error("time constant period exceeds counter width");
  end

  cfg_state_t s_q;
  cfg_state_t s_d;
  logic addr_take;
  logic [5:0] addr_idx;
  logic addr_hit;
  logic [7:0] wbyte;
  logic [TC_CNT_W-1:0] tc_period;
  logic [1:0] tconst_code;
  logic freeze;
  logic [11:0] ofs_sum;
  logic fine_active;
  logic fast_active;

  // Bus is stalled while the clock enable is low so no phase is lost
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, s_q.rdata};

  assign addr_take = hsel && htrans[1] && hready && ce;
  assign addr_idx = haddr[7:2];
  assign addr_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  assign wbyte = hwdata[7:0];

  assign tconst_code = s_q.dc_hi[TCONST_LSB +: 2];
  assign freeze = s_q.dc_hi[FREEZE_BIT];

  always_comb begin
    case (tconst_code)
      TCONST_SLOW: tc_period = TC_CNT_W'(TC_SLOW_CYCLES - 1);
      TCONST_MEDIUM: tc_period = TC_CNT_W'(TC_MEDIUM_CYCLES - 1);
      TCONST_FAST: tc_period = TC_CNT_W'(TC_FAST_CYCLES - 1);
      TCONST_QUALITY: begin
        // A clean signal tolerates the slow loop; a poor one needs fast tracking
        tc_period = video_quality_indication ? TC_CNT_W'(TC_SLOW_CYCLES - 1)
                                             : TC_CNT_W'(TC_FAST_CYCLES - 1);
      end
      default: tc_period = TC_CNT_W'(TC_SLOW_CYCLES - 1);
    endcase
  end

  assign digital_clamp_offset = {s_q.dc_hi[OFS_HI_LSB +: 4], s_q.dc_lo};
  assign ofs_sum = adc_raw + digital_clamp_offset;

  always_comb begin
    s_d = s_q;
    // Data phase of a write: registers change at this edge, fields act next cycle
    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        IDX_TIMING: s_d.timing = wbyte;
        IDX_ICTRL: s_d.ictrl = wbyte;
        IDX_CLAMP: s_d.clamp = wbyte & CLAMP_WMASK;
        IDX_DC_HI: s_d.dc_hi = wbyte;
        IDX_DC_LO: s_d.dc_lo = wbyte;
        IDX_FILT: s_d.filt = wbyte;
        default: s_d.timing = s_q.timing;
      endcase
    end
    s_d.wr_pend = 1'b0;
    if (addr_take) begin
      s_d.wr_pend = hwrite && addr_hit;
      s_d.wr_idx = addr_idx;
      if (!hwrite) begin
        // Read from the updated copy so a write just ahead is seen
        if (!addr_hit) begin
          s_d.rdata = 8'h00;
        end else begin
          case (addr_idx)
            IDX_IDENT: s_d.rdata = REVISION;
            IDX_TIMING: s_d.rdata = s_d.timing;
            IDX_ICTRL: s_d.rdata = s_d.ictrl;
            IDX_CLAMP: s_d.rdata = s_d.clamp;
            IDX_DC_HI: s_d.rdata = s_d.dc_hi;
            IDX_DC_LO: s_d.rdata = s_d.dc_lo;
            IDX_FILT: s_d.rdata = s_d.filt;
            default: s_d.rdata = 8'h00;
          endcase
        end
      end
    end
    // Manual offset applies to every sample here; auto mode passes raw data
    s_d.core_data = s_q.dc_hi[MODE_BIT] ? ofs_sum : adc_raw;
    s_d.tick = 1'b0;
    if (!freeze) begin
      if (s_q.tc_cnt == '0) begin
        s_d.tick = 1'b1;
        s_d.tc_cnt = tc_period;
      end else begin
        s_d.tc_cnt = s_q.tc_cnt - TC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.timing <= TIMING_RST;
      s_q.ictrl <= ICTRL_RST;
      s_q.clamp <= CLAMP_RST;
      s_q.dc_hi <= DC_HI_RST;
      s_q.dc_lo <= DC_LO_RST;
      s_q.filt <= FILT_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Sync, vsync and field drivers
  assign timing_drive_en = s_q.ictrl[FORCE_BIT]
                           || (!output_enable_n && !s_q.timing[TIMING_DISABLE_BIT]);

  clamp_pulse_timer u_fine (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(clamp_start),
    .code(s_q.clamp[FINE_LSB +: 2]),
    .active(fine_active)
  );

  clamp_pulse_timer u_fast (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(clamp_start),
    .code(s_q.clamp[FAST_LSB +: 2]),
    .active(fast_active)
  );

  assign fine_current_on = fine_active && s_q.clamp[CURRENT_EN_BIT];
  assign fast_current_on = fast_active && s_q.clamp[CURRENT_EN_BIT];
  assign voltage_clamp_on = s_q.clamp[VOLTAGE_EN_BIT];

  assign digital_clamp_run = !freeze;
  assign digital_clamp_tick = s_q.tick;
  assign manual_offset_mode = s_q.dc_hi[MODE_BIT];
  assign core_data = s_q.core_data;

  assign luma_filter_select = s_q.filt[LUMA_LSB +: 5];
  assign luma_filter_valid = (luma_filter_select != LUMA_UNUSED);
  assign chroma_filter_select = s_q.filt[CHROMA_LSB +: 3];

  always_comb begin
    case (chroma_filter_select)
      CHROMA_AUTO_15: chroma_filter_active = CHROMA_SH1 + {1'b0, scale_range};
      CHROMA_AUTO_217: chroma_filter_active = CHROMA_SH2 + {1'b0, scale_range};
      default: chroma_filter_active = chroma_filter_select;
    endcase
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ident_read;
    (addr_take && !hwrite && addr_hit && addr_idx == IDX_IDENT) |=> (hrdata[7:0] == REVISION);
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("revision read wrong");

  property p_ident_ro;
    (ce && s_q.wr_pend && s_q.wr_idx == IDX_IDENT) |=> $stable(s_q[$bits(cfg_state_t)-1 -: 48]);
  endproperty
  a_ident_ro: assert property (p_ident_ro) else $error("revision write changed a register");

  property p_force;
    s_q.ictrl[FORCE_BIT] |-> timing_drive_en;
  endproperty
  a_force: assert property (p_force) else $error("forced drivers inactive");

  property p_follow_oe;
    (!s_q.ictrl[FORCE_BIT] && output_enable_n) |-> !timing_drive_en;
  endproperty
  a_follow_oe: assert property (p_follow_oe) else $error("drivers on without enable");

  property p_current_off;
    !s_q.clamp[CURRENT_EN_BIT] |-> !(fine_current_on || fast_current_on);
  endproperty
  a_current_off: assert property (p_current_off) else $error("current on while disabled");

  property p_reserved_zero;
    s_q.clamp[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved clamp bits set");

  property p_manual_add;
    (ce && manual_offset_mode) |=> (core_data == $past(ofs_sum));
  endproperty
  a_manual_add: assert property (p_manual_add) else $error("manual offset not applied");

  property p_auto_pass;
    (ce && !manual_offset_mode) |=> (core_data == $past(adc_raw));
  endproperty
  a_auto_pass: assert property (p_auto_pass) else $error("auto mode altered data");

  property p_freeze;
    (ce && freeze) |=> (!digital_clamp_tick && $stable(s_q.tc_cnt));
  endproperty
  a_freeze: assert property (p_freeze) else $error("loop ran while frozen");

  property p_tc_reload;
    (ce && !freeze && s_q.tc_cnt == '0) |=> (digital_clamp_tick && s_q.tc_cnt == $past(tc_period));
  endproperty
  a_tc_reload: assert property (p_tc_reload) else $error("time constant reload wrong");

  property p_write_back;
    (ce && s_q.wr_pend && s_q.wr_idx == IDX_DC_LO) |=> (s_q.dc_lo == $past(hwdata[7:0]));
  endproperty
  a_write_back: assert property (p_write_back) else $error("write not stored");

  property p_luma_unused;
    (luma_filter_select == LUMA_UNUSED) |-> !luma_filter_valid;
  endproperty
  a_luma_unused: assert property (p_luma_unused) else $error("unused luma code valid");

  property p_chroma_auto;
    (chroma_filter_select == CHROMA_AUTO_15) |-> (chroma_filter_active >= CHROMA_SH1);
  endproperty
  a_chroma_auto: assert property (p_chroma_auto) else $error("auto chroma not a fixed filter");

  property p_chroma_fixed;
    (chroma_filter_select >= CHROMA_SH1) |-> (chroma_filter_active == chroma_filter_select);
  endproperty
  a_chroma_fixed: assert property (p_chroma_fixed) else $error("fixed chroma filter altered");

  property p_drive_follow;
    (!s_q.ictrl[FORCE_BIT] && !output_enable_n && !s_q.timing[TIMING_DISABLE_BIT])
      |-> timing_drive_en;
  endproperty
  a_drive_follow: assert property (p_drive_follow) else $error("enabled drivers stay off");

  property p_unmapped_read;
    (addr_take && !hwrite && (!addr_hit || addr_idx < IDX_IDENT || addr_idx > IDX_FILT))
      |=> (hrdata == 32'h00000000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

endmodule
`default_nettype wire

// ### testbench/video_clamp_filter_config_regs_bench.sv
// Self-checking bench for the clamp and filter configuration bank
`timescale 1ns/1ps
`default_nettype none
module video_clamp_filter_config_regs_bench import clamp_cfg_pkg::*; ();
  // Revision value is arbitrary; tick periods shortened for run time
  localparam logic [7:0] REV = 8'h3c;
  localparam int TS = 40;
  localparam int TM = 20;
  localparam int TF = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  logic hreadyout, hresp, timing_drive_en, fine_current_on, fast_current_on, voltage_clamp_on;
  logic [31:0] hrdata;
  logic output_enable_n = 1'b1;
  logic clamp_start = 1'b0;
  logic vqi = 1'b0;
  logic digital_clamp_run, digital_clamp_tick, manual_offset_mode, luma_filter_valid;
  logic [11:0] digital_clamp_offset, core_data;
  logic [11:0] adc_raw = 12'h0;
  logic [4:0] luma_filter_select;
  logic [2:0] chroma_filter_select, chroma_filter_active;
  logic [1:0] scale_range = 2'h0;
  int failures = 0;
  int compares = 0;
  assign hready = hreadyout;

  video_clamp_filter_config_regs #(.REVISION(REV), .TC_SLOW_CYCLES(TS), .TC_MEDIUM_CYCLES(TM),
    .TC_FAST_CYCLES(TF)) video_clamp_filter_config_regs_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .output_enable_n(output_enable_n),
    .timing_drive_en(timing_drive_en), .clamp_start(clamp_start),
    .fine_current_on(fine_current_on), .fast_current_on(fast_current_on),
    .voltage_clamp_on(voltage_clamp_on), .video_quality_indication(vqi),
    .digital_clamp_run(digital_clamp_run), .digital_clamp_tick(digital_clamp_tick),
    .manual_offset_mode(manual_offset_mode), .digital_clamp_offset(digital_clamp_offset),
    .adc_raw(adc_raw), .core_data(core_data), .luma_filter_select(luma_filter_select),
    .luma_filter_valid(luma_filter_valid), .chroma_filter_select(chroma_filter_select),
    .scale_range(scale_range), .chroma_filter_active(chroma_filter_active));

  initial begin
    forever #50 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One single AHB-Lite transfer; waits on hready in both phases
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] r);
    xfer(1'b0, idx, 8'h00, r);
  endtask

  // Distance in cycles from one tick to the next
  task automatic tick_gap(output int n);
    n = 0;
    while (digital_clamp_tick !== 1'b1 && n < 500) begin
      @(negedge hclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (digital_clamp_tick !== 1'b1 && n < 500);
  endtask

  initial begin
    #3_000_000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    logic [5:0] ix [8];
    logic [7:0] rv [8];
    logic [7:0] p, e;
    logic [31:0] r;
    logic [2:0] c, ca;
    logic [1:0] code;
    logic f, d, cur;
    int nf, nq, n;
    int tv [5];
    ix = '{IDX_IDENT, IDX_TIMING, IDX_ICTRL, IDX_CLAMP, IDX_DC_HI, IDX_DC_LO, IDX_FILT, 6'h10};
    rv = '{REV, TIMING_RST, ICTRL_RST, CLAMP_RST, DC_HI_RST, DC_LO_RST, FILT_RST, 8'h00};
    tv = '{TS, TM, TF, TS, TF};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      rd(ix[i], r);
      check(r, {24'h0, rv[i]});
    end
    // Write then read at once; reserved internal bits kept at default
    for (int i = 0; i < 8; i++) begin
      p = (ix[i] == IDX_ICTRL) ? ICTRL_RST : 8'hda ^ 8'(i);
      e = (ix[i] == IDX_IDENT) ? REV : (ix[i] == IDX_CLAMP) ? (p & CLAMP_WMASK) : p;
      if (ix[i] == 6'h10) e = 8'h00;
      wr(ix[i], p);
      rd(ix[i], r);
      check(r, {24'h0, e});
    end
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      f = k[2];
      d = k[1];
      wr(IDX_TIMING, 8'(d) << TIMING_DISABLE_BIT);
      wr(IDX_ICTRL, ICTRL_RST | (8'(f) << FORCE_BIT));
      output_enable_n <= k[0];
      @(posedge hclk);
      #1;
      check(32'(timing_drive_en), 32'(f | (!k[0] & !d)));
    end
    $display("test timing drive done");
    for (int k = 0; k < 5; k++) begin
      code = k[1:0];
      cur = (k != 4);
      wr(IDX_CLAMP, {2'b00, 1'b1, cur, ~code, code});
      @(posedge hclk);
      clamp_start <= 1'b1;
      @(posedge hclk);
      clamp_start <= 1'b0;
      nf = 0;
      nq = 0;
      repeat (300) begin
        @(negedge hclk);
        nf += int'(fine_current_on === 1'b1);
        nq += int'(fast_current_on === 1'b1);
      end
      check(32'(nf), cur ? 32'(16) << code : 32'h0);
      check(32'(nq), cur ? 32'(16) << ~code : 32'h0);
      check(32'(voltage_clamp_on), 32'h1);
      @(posedge hclk);
    end
    wr(IDX_CLAMP, 8'h00);
    #1;
    check(32'(voltage_clamp_on), 32'h0);
    $display("test analog clamp done");
    for (int k = 0; k < 5; k++) begin
      vqi <= (k == 3);
      wr(IDX_DC_HI, 8'(k > 3 ? 3 : k) << TCONST_LSB);
      tick_gap(n);
      tick_gap(n);
      check(32'(n), 32'(tv[k]));
      @(posedge hclk);
    end
    wr(IDX_DC_HI, 8'h50);
    @(negedge hclk);
    n = 0;
    repeat (60) begin
      @(negedge hclk);
      n += int'(digital_clamp_tick === 1'b1);
    end
    check(32'(n), 32'h0);
    check(32'(digital_clamp_run), 32'h0);
    @(posedge hclk);
    wr(IDX_DC_HI, 8'h40);
    tick_gap(n);
    check(32'(n), 32'(TF));
    check(32'(digital_clamp_run), 32'h1);
    $display("test digital clamp loop done");
    @(posedge hclk);
    wr(IDX_DC_HI, 8'h8a);
    wr(IDX_DC_LO, 8'h37);
    adc_raw <= 12'h700;
    repeat (3) @(posedge hclk);
    #1;
    check(32'(digital_clamp_offset), 32'ha37);
    check(32'(manual_offset_mode), 32'h1);
    check(32'(core_data), 32'h137);
    wr(IDX_DC_HI, 8'h0a);
    adc_raw <= 12'h0f0;
    repeat (3) @(posedge hclk);
    #1;
    check(32'(manual_offset_mode), 32'h0);
    check(32'(core_data), 32'h0f0);
    // Clock enable low stalls the bus and freezes the datapath
    ce <= 1'b0;
    adc_raw <= 12'h555;
    repeat (3) @(posedge hclk);
    #1;
    check(32'(hreadyout), 32'h0);
    check(32'(core_data), 32'h0f0);
    ce <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    check(32'(core_data), 32'h555);
    $display("test offset done");
    for (int l = 0; l < 32; l++) begin
      c = 3'(l);
      scale_range <= 2'(l >> 3);
      wr(IDX_FILT, {c, 5'(l)});
      #1;
      ca = (c == CHROMA_AUTO_15) ? 3'(CHROMA_SH1 + 3'(l >> 3)) :
           (c == CHROMA_AUTO_217) ? 3'(CHROMA_SH2 + 3'(l >> 3)) : c;
      check(32'(luma_filter_select), 32'(l));
      check(32'(luma_filter_valid), 32'(5'(l) != LUMA_UNUSED));
      check(32'(chroma_filter_select), 32'(c));
      check(32'(chroma_filter_active), 32'(ca));
    end
    $display("test shaping filters done");
    report_and_stop();
  end
endmodule
`default_nettype wire
